// ==== shared/eeprom_bus_pkg.sv ====
// Functional notes
// [RULE1] Master changes data only while clock low.
// [RULE2] Data falling while clock high means start.
// [RULE3] Data rising while clock high means stop.
// [RULE4] Stop after a read enters standby.
// [RULE5] Eight-bit words, target acknowledges on ninth clock.
// [RULE6] Standby after power-up and after stop; after a write's stop, only once the write timer ends.
// [RULE7] Master recovers with nine clocks, then start; the code stops clocking early once data reads high.
// [RULE8] Address word follows every start condition.
// [RULE9] Top four address bits must match preamble.
// [RULE10] Next three bits compared with strap pins.
// [RULE11] Floating straps count as logic low.
// [RULE12] Module variant requires those three bits zero.
// [RULE13] Eighth bit selects read or write.
// [RULE14] Match acknowledges; mismatch stays silent, standby.
// [RULE15] Internal write finishes within five milliseconds.
// [RULE16] Busy writing: ignore bus, never acknowledge.
// [RULE17] Master sends two address bytes before data.
// [RULE18] Target only pulls data low or releases.
// [RULE19] Start mid-transaction restarts address reception.
package eeprom_bus_pkg;

  localparam int         CLK_PERIOD_NS = 25;
  localparam int         T_LOW_NS      = 1300;
  localparam int         QUARTER_CYC   = (T_LOW_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int         WR_TIME_MS    = 5;
  localparam int         WR_CYCLES     = (WR_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int         WORD_W        = 8;
  localparam int         FIFO_DEPTH    = 16;
  localparam int         STRAP_W       = 3;
  localparam logic [3:0] PREAMBLE      = 4'ha;
  localparam logic [2:0] MODULE_SEL    = 3'h0;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [3:0] ACK_SLOT      = 4'h8;
  localparam logic [3:0] REC_LAST      = 4'h8;
  localparam logic [1:0] ADDR_BYTES    = 2'h2;

endpackage : eeprom_bus_pkg

// ==== shared/two_wire_if.sv ====
`timescale 1ns/1ps
interface two_wire_if;
  logic scl;
  logic sda;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;

  // Wired-AND of both open-drain drivers with the pull-up.
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport target (
    input  scl,
    input  sda,
    output dev_sda_o,
    output dev_sda_oe
  );

  modport master (
    output scl,
    input  sda,
    output host_sda_o,
    output host_sda_oe
  );
endinterface : two_wire_if

// ==== design/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = count_r != (AW+1)'(DEPTH);
  assign out_valid = count_r != '0;
  assign out_data  = mem_r[rd_ptr_r];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap naturally, so DEPTH must be a power of two.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_r <= '0;
    end else if (push && !pop) begin
      count_r <= count_r + 1'b1;
    end else if (pop && !push) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule : word_fifo

// ==== design/eeprom_target.sv ====
`timescale 1ns/1ps
module eeprom_target #(
  parameter int WR_CYCLES      = eeprom_bus_pkg::WR_CYCLES,
  parameter bit MODULE_VARIANT = 1'h0
) (
  input  wire logic                                  clock,
  input  wire logic                                  rst,
  two_wire_if.target                                 link,
  input  wire logic [eeprom_bus_pkg::STRAP_W-1:0]    device_select_straps,
  output logic                                       out_valid,
  input  wire logic                                  out_ready,
  output logic      [eeprom_bus_pkg::WORD_W-1:0]     out_data,
  output logic                                       standby,
  output logic                                       write_busy
);
  localparam int TW = $clog2(WR_CYCLES + 1);

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_WRITE, M_READ} mode_t;

  // Frame conditions, clocked by the data line itself.
  logic start_tgl_r;
  logic stop_tgl_r;

  // Link clock domain.
  mode_t                                mode_r;
  logic                                 start_seen_r;
  logic                                 stop_seen_r;
  logic [3:0]                           bit_cnt_r;
  logic [6:0]                           shift_r;
  logic                                 ack_pend_r;
  logic [1:0]                           byte_cnt_r;
  logic                                 wr_seq_r;
  logic [eeprom_bus_pkg::WORD_W-1:0]    word_r;
  logic                                 word_tgl_r;
  logic                                 selected_r;
  logic                                 sda_drive_r;
  logic [eeprom_bus_pkg::STRAP_W-1:0]   strap_m_r;
  logic [eeprom_bus_pkg::STRAP_W-1:0]   strap_r;
  logic                                 busy_m_r;
  logic                                 busy_l_r;
  logic                                 room_m_r;
  logic                                 room_l_r;
  logic [7:0]                           rx_byte;
  logic [eeprom_bus_pkg::STRAP_W-1:0]   sel_bits;
  logic                                 addr_hit;
  logic                                 new_start;
  logic                                 new_stop;
  logic                                 take_byte;

  // System clock domain.
  logic          stop_m_r;
  logic          stop_s_r;
  logic          stop_d_r;
  logic          word_m_r;
  logic          word_s_r;
  logic          word_d_r;
  logic          wseq_m_r;
  logic          wseq_s_r;
  logic          sel_m_r;
  logic          sel_s_r;
  logic          sel_d_r;
  logic          busy_r;
  logic [TW-1:0] timer_r;
  logic          standby_r;
  logic          room_r;
  logic          stop_ev;
  logic          word_ev;
  logic          sel_rise;
  logic          fifo_in_ready;

  // Start and stop are the only data edges allowed while the clock is high.
  always_ff @(negedge link.sda or posedge rst) begin
    if (rst) begin
      start_tgl_r <= 1'h0;
    end else if (link.scl) begin
      start_tgl_r <= ~start_tgl_r; // [RULE2]
    end
  end

  always_ff @(posedge link.sda or posedge rst) begin
    if (rst) begin
      stop_tgl_r <= 1'h0;
    end else if (link.scl) begin
      stop_tgl_r <= ~stop_tgl_r; // [RULE3]
    end
  end

  // The toggles settle a setup time before the next clock rise, which is
  // why they are compared directly instead of through two flops.
  assign new_start = start_tgl_r != start_seen_r;
  assign new_stop  = stop_tgl_r != stop_seen_r;
  assign rx_byte   = {shift_r, link.sda};
  assign sel_bits  = MODULE_VARIANT ? eeprom_bus_pkg::MODULE_SEL : strap_r; // [RULE12]
  assign addr_hit  = (rx_byte[7:4] == eeprom_bus_pkg::PREAMBLE) && // [RULE9]
                     (rx_byte[3:1] == sel_bits); // [RULE10]
  assign take_byte = !new_start && !new_stop && (mode_r == M_WRITE) &&
                     (bit_cnt_r == eeprom_bus_pkg::LAST_BIT) && room_l_r;

  // Straps are static; the pads pull floating pins low before they get here.
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      strap_m_r <= '0;
      strap_r   <= '0;
      busy_m_r  <= 1'h0;
      busy_l_r  <= 1'h0;
      room_m_r  <= 1'h0;
      room_l_r  <= 1'h0;
    end else begin
      strap_m_r <= device_select_straps; // [RULE11]
      strap_r   <= strap_m_r;
      busy_m_r  <= busy_r;
      busy_l_r  <= busy_m_r;
      room_m_r  <= room_r;
      room_l_r  <= room_m_r;
    end
  end

  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      mode_r       <= M_IDLE;
      start_seen_r <= 1'h0;
      stop_seen_r  <= 1'h0;
      bit_cnt_r    <= '0;
      shift_r      <= '0;
      ack_pend_r   <= 1'h0;
      byte_cnt_r   <= '0;
      wr_seq_r     <= 1'h0;
    end else begin
      start_seen_r <= start_tgl_r;
      stop_seen_r  <= stop_tgl_r;
      if (new_start) begin
        mode_r     <= M_ADDR; // [RULE8] [RULE19]
        bit_cnt_r  <= 4'h1;
        shift_r    <= {6'h00, link.sda};
        ack_pend_r <= 1'h0;
        byte_cnt_r <= '0;
        wr_seq_r   <= 1'h0;
      end else if (new_stop || mode_r == M_IDLE) begin
        mode_r     <= M_IDLE;
        bit_cnt_r  <= '0;
        ack_pend_r <= 1'h0;
      end else if (bit_cnt_r == eeprom_bus_pkg::ACK_SLOT) begin
        bit_cnt_r <= '0;
      end else begin
        shift_r   <= rx_byte[6:0];
        bit_cnt_r <= bit_cnt_r + 4'h1; // [RULE5]
        if (bit_cnt_r == eeprom_bus_pkg::LAST_BIT) begin
          unique case (mode_r)
            M_ADDR: begin
              if (addr_hit && !busy_l_r) begin
                ack_pend_r <= 1'h1; // [RULE14] [RULE16]
                mode_r     <= rx_byte[0] ? M_READ : M_WRITE; // [RULE13]
              end else begin
                ack_pend_r <= 1'h0; // [RULE14]
                mode_r     <= M_IDLE;
              end
            end
            M_WRITE: begin
              // A full buffer is refused with no acknowledge.
              ack_pend_r <= room_l_r;
              if (room_l_r && byte_cnt_r == eeprom_bus_pkg::ADDR_BYTES) begin
                wr_seq_r <= 1'h1; // [RULE17]
              end else if (room_l_r) begin
                byte_cnt_r <= byte_cnt_r + 2'h1;
              end
            end
            M_READ: begin
              ack_pend_r <= 1'h0;
            end
            M_IDLE: begin
              ack_pend_r <= 1'h0;
            end
          endcase
        end
      end
    end
  end

  // The word stays put for nine link clocks, long enough to be sampled.
  always_ff @(posedge link.scl or posedge rst) begin
    if (rst) begin
      word_r     <= '0;
      word_tgl_r <= 1'h0;
      selected_r <= 1'h0;
    end else begin
      selected_r <= (mode_r == M_WRITE) || (mode_r == M_READ);
      if (take_byte) begin
        word_r     <= rx_byte;
        word_tgl_r <= ~word_tgl_r;
      end
    end
  end

  // Acknowledge is changed on the falling clock so it is stable while high.
  always_ff @(negedge link.scl or posedge rst) begin
    if (rst) begin
      sda_drive_r <= 1'h0;
    end else begin
      sda_drive_r <= ack_pend_r && (bit_cnt_r == eeprom_bus_pkg::ACK_SLOT); // [RULE5]
    end
  end

  assign link.dev_sda_o  = 1'h0; // [RULE18]
  assign link.dev_sda_oe = sda_drive_r; // [RULE18]

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stop_m_r <= 1'h0;
      stop_s_r <= 1'h0;
      stop_d_r <= 1'h0;
      word_m_r <= 1'h0;
      word_s_r <= 1'h0;
      word_d_r <= 1'h0;
      wseq_m_r <= 1'h0;
      wseq_s_r <= 1'h0;
      sel_m_r  <= 1'h0;
      sel_s_r  <= 1'h0;
      sel_d_r  <= 1'h0;
      room_r   <= 1'h0;
    end else begin
      stop_m_r <= stop_tgl_r;
      stop_s_r <= stop_m_r;
      stop_d_r <= stop_s_r;
      word_m_r <= word_tgl_r;
      word_s_r <= word_m_r;
      word_d_r <= word_s_r;
      wseq_m_r <= wr_seq_r;
      wseq_s_r <= wseq_m_r;
      sel_m_r  <= selected_r;
      sel_s_r  <= sel_m_r;
      sel_d_r  <= sel_s_r;
      room_r   <= fifo_in_ready;
    end
  end

  assign stop_ev  = stop_s_r ^ stop_d_r;
  assign word_ev  = word_s_r ^ word_d_r;
  assign sel_rise = sel_s_r & ~sel_d_r;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_r  <= 1'h0;
      timer_r <= '0;
    end else if (stop_ev && wseq_s_r && !busy_r) begin
      busy_r  <= 1'h1; // [RULE15]
      timer_r <= TW'(WR_CYCLES - 1);
    end else if (busy_r) begin
      if (timer_r == '0) begin
        busy_r <= 1'h0; // [RULE15]
      end else begin
        timer_r <= timer_r - 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      standby_r <= 1'h1; // [RULE6]
    end else if (sel_rise) begin
      standby_r <= 1'h0;
    // A stop that lands during the internal write leaves standby to the timer.
    end else if (stop_ev && !wseq_s_r && !busy_r) begin
      standby_r <= 1'h1; // [RULE4] [RULE6]
    end else if (busy_r && timer_r == '0) begin
      standby_r <= 1'h1; // [RULE6]
    end
  end

  assign standby    = standby_r;
  assign write_busy = busy_r;

  word_fifo #(
    .WIDTH (eeprom_bus_pkg::WORD_W),
    .DEPTH (eeprom_bus_pkg::FIFO_DEPTH)
  ) rx_fifo (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (word_ev),
    .in_ready  (fifo_in_ready),
    .in_data   (word_r),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );
endmodule : eeprom_target

// ==== design/bus_master.sv ====
`timescale 1ns/1ps
module bus_master (
  input  wire logic       clock,
  input  wire logic       rst,
  two_wire_if.master      link,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_start,
  input  wire logic       cmd_stop,
  input  wire logic       cmd_recover,
  input  wire logic [7:0] cmd_byte,
  output logic            result_valid,
  output logic            result_nack,
  output logic      [7:0] result_byte
);
  localparam int QW = $clog2(eeprom_bus_pkg::QUARTER_CYC);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BITS, H_STOP, H_RECOVER} hstate_t;

  hstate_t       state_r;
  logic [QW-1:0] q_cnt_r;
  logic [1:0]    phase_r;
  logic [3:0]    bit_r;
  logic [7:0]    byte_r;
  logic [7:0]    rx_r;
  logic          stop_after_r;
  logic          recov_r;
  logic [3:0]    rec_cnt_r;
  logic          scl_r;
  logic          sda_oe_r;
  logic          cmd_ready_r;
  logic          result_valid_r;
  logic          result_nack_r;
  logic [7:0]    result_byte_r;
  logic          sda_m_r;
  logic          sda_s_r;
  logic          tick;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sda_m_r <= 1'h1;
      sda_s_r <= 1'h1;
    end else begin
      sda_m_r <= link.sda;
      sda_s_r <= sda_m_r;
    end
  end

  assign tick = q_cnt_r == QW'(eeprom_bus_pkg::QUARTER_CYC - 1);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      q_cnt_r <= '0;
    end else if (state_r == H_IDLE || tick) begin
      q_cnt_r <= '0;
    end else begin
      q_cnt_r <= q_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r        <= H_IDLE;
      phase_r        <= '0;
      bit_r          <= '0;
      byte_r         <= '0;
      rx_r           <= '0;
      stop_after_r   <= 1'h0;
      recov_r        <= 1'h0;
      rec_cnt_r      <= '0;
      scl_r          <= 1'h1;
      sda_oe_r       <= 1'h0;
      cmd_ready_r    <= 1'h1;
      result_valid_r <= 1'h0;
      result_nack_r  <= 1'h0;
      result_byte_r  <= '0;
    end else begin
      result_valid_r <= 1'h0;
      if (state_r == H_IDLE) begin
        if (cmd_valid && cmd_ready_r) begin
          cmd_ready_r  <= 1'h0;
          byte_r       <= cmd_byte;
          stop_after_r <= cmd_stop;
          recov_r      <= cmd_recover;
          phase_r      <= '0;
          bit_r        <= '0;
          rec_cnt_r    <= '0;
          if (cmd_recover) begin
            state_r <= H_RECOVER;
          end else if (cmd_start || scl_r) begin
            state_r <= H_START; // [RULE2] [RULE8]
          end else begin
            state_r <= H_BITS;
          end
        end
      end else if (tick) begin
        phase_r <= phase_r + 2'h1;
        unique case (state_r)
          H_START: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'h0;
              2'h1: scl_r <= 1'h1;
              2'h2: sda_oe_r <= 1'h1; // [RULE2]
              2'h3: begin
                scl_r   <= 1'h0;
                state_r <= recov_r ? H_STOP : H_BITS;
              end
            endcase
          end
          H_BITS: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= (bit_r == eeprom_bus_pkg::ACK_SLOT) ? 1'h0 : ~byte_r[7]; // [RULE1]
              2'h1: scl_r <= 1'h1;
              2'h2: begin
                if (bit_r == eeprom_bus_pkg::ACK_SLOT) begin
                  result_nack_r <= sda_s_r; // [RULE5]
                end else begin
                  rx_r <= {rx_r[6:0], sda_s_r};
                end
              end
              2'h3: begin
                scl_r  <= 1'h0;
                byte_r <= {byte_r[6:0], 1'h0};
                if (bit_r == eeprom_bus_pkg::ACK_SLOT) begin
                  result_valid_r <= 1'h1;
                  result_byte_r  <= rx_r;
                  state_r        <= stop_after_r ? H_STOP : H_IDLE;
                  cmd_ready_r    <= !stop_after_r;
                end else begin
                  bit_r <= bit_r + 4'h1;
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'h1;
              2'h1: scl_r <= 1'h1;
              2'h2: sda_oe_r <= 1'h0; // [RULE3]
              2'h3: begin
                state_r     <= H_IDLE;
                cmd_ready_r <= 1'h1;
              end
            endcase
          end
          H_RECOVER: begin
            unique case (phase_r)
              2'h0: sda_oe_r <= 1'h0;
              2'h1: scl_r <= 1'h1;
              2'h2: ;
              2'h3: begin
                scl_r <= 1'h0;
                if (sda_s_r || rec_cnt_r == eeprom_bus_pkg::REC_LAST) begin
                  state_r <= H_START; // [RULE7]
                end else begin
                  rec_cnt_r <= rec_cnt_r + 4'h1; // [RULE7]
                end
              end
            endcase
          end
          H_IDLE: ;
        endcase
      end
    end
  end

  assign link.scl         = scl_r;
  assign link.host_sda_o  = 1'h0;
  assign link.host_sda_oe = sda_oe_r;
  assign cmd_ready        = cmd_ready_r;
  assign result_valid     = result_valid_r;
  assign result_nack      = result_nack_r;
  assign result_byte      = result_byte_r;
endmodule : bus_master

// ==== verification/two_wire_asserts.sv ====
`timescale 1ns/1ps
module two_wire_asserts (
  input wire logic clock,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe
);
  logic       scl_q_r;
  logic       sda_q_r;
  logic [3:0] bit_cnt_r;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_q_r <= 1'h1;
      sda_q_r <= 1'h1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end

  // A start clears the count so that an aborted word cannot shift the ack slot.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 4'h0;
    end else if (scl && scl_q_r && sda_q_r && !sda) begin
      bit_cnt_r <= 4'h0;
    end else if (scl && !scl_q_r) begin
      bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
    end
  end

  open_drain_a: assert property ((dev_sda_o == 1'h0) && (!dev_sda_oe || !sda))
    else $error("target drove the data line high");
  ack_slot_a: assert property ($rose(dev_sda_oe) |-> !scl && bit_cnt_r == 4'h8)
    else $error("ack not after the eighth clock");
  ack_length_a: assert property ($rose(dev_sda_oe) |-> ##[100:108] $fell(dev_sda_oe))
    else $error("ack not one link clock period long");
  ack_release_a: assert property ($fell(dev_sda_oe) |-> !scl)
    else $error("ack released while link clock high");
  ack_alone_a: assert property (dev_sda_oe && scl |-> !host_sda_oe)
    else $error("ack while the master still drives");
  data_stable_a: assert property ($rose(scl) |-> $stable(sda) [*8])
    else $error("data moved just after link clock rise");
  start_hold_a: assert property (scl && sda_q_r && !sda |-> ##[24:28] $fell(scl))
    else $error("start not followed by a clock fall");
  stop_idle_a: assert property (scl && !sda_q_r && sda |-> scl [*8])
    else $error("link clock moved right after a stop");

  cover property ($rose(dev_sda_oe));
  cover property (scl && sda_q_r && !sda);
  cover property (scl && !sda_q_r && sda);
endmodule : two_wire_asserts

// ==== verification/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  localparam int WR_P = 3000;
  typedef struct packed {
    logic [2:0] straps;
    logic [7:0] addr;
    logic       nack;
    logic       nack2;
  } row_t;
  row_t rows [7] = '{'{3'h5, 8'haa, 1'h0, 1'h1}, '{3'h5, 8'hab, 1'h0, 1'h1},
                     '{3'h5, 8'ha0, 1'h1, 1'h0}, '{3'h5, 8'h2a, 1'h1, 1'h1},
                     '{3'h5, 8'hba, 1'h1, 1'h1}, '{3'h7, 8'hae, 1'h0, 1'h1},
                     '{3'h0, 8'ha1, 1'h0, 1'h0}};
  logic       clock;
  logic       rst;
  logic       cmd_valid;
  logic       cmd_ready;
  logic       cmd_start;
  logic       cmd_stop;
  logic       cmd_recover;
  logic [7:0] cmd_byte;
  logic       result_valid;
  logic       result_nack;
  logic       result_nack2;
  logic [7:0] result_byte;
  logic [2:0] straps;
  logic       out_valid;
  logic       out_ready;
  logic [7:0] out_data;
  logic       standby;
  logic       write_busy;
  int         err_total;
  int         n_tests;
  int         i;

  two_wire_if link_if ();
  two_wire_if link2_if ();

  bus_master bus_master_inst (.clock(clock), .rst(rst), .link(link_if), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_recover(cmd_recover),
    .cmd_byte(cmd_byte), .result_valid(result_valid), .result_nack(result_nack),
    .result_byte(result_byte));
  eeprom_target #(.WR_CYCLES(WR_P)) eeprom_target_inst (.clock(clock), .rst(rst), .link(link_if),
    .device_select_straps(straps), .out_valid(out_valid), .out_ready(out_ready),
    .out_data(out_data), .standby(standby), .write_busy(write_busy));
  // The variant pair shares the command inputs, so both masters run in lockstep.
  bus_master bus_master_var_inst (.clock(clock), .rst(rst), .link(link2_if),
    .cmd_valid(cmd_valid), .cmd_ready(), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_recover(cmd_recover), .cmd_byte(cmd_byte), .result_valid(),
    .result_nack(result_nack2), .result_byte());
  eeprom_target #(.WR_CYCLES(WR_P), .MODULE_VARIANT(1'h1)) eeprom_target_var_inst (.clock(clock),
    .rst(rst), .link(link2_if), .device_select_straps(3'h7), .out_valid(), .out_ready(1'h1),
    .out_data(), .standby(), .write_busy());
  two_wire_asserts two_wire_asserts_inst (.clock(clock), .rst(rst), .scl(link_if.scl),
    .sda(link_if.sda), .host_sda_oe(link_if.host_sda_oe), .dev_sda_o(link_if.dev_sda_o),
    .dev_sda_oe(link_if.dev_sda_oe));

  always #12.5 clock = ~clock;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic pick(input int sel);
    case (sel)
      0: return cmd_ready;
      1: return result_valid;
      2: return out_valid;
      default: return !write_busy;
    endcase
  endfunction : pick

  task automatic wait_on(input int sel, input int lim);
    for (int k = 0; k < lim; k++) begin
      @(negedge clock);
      if (pick(sel) === 1'h1) return;
    end
    err_total++;
    finish_test();
  endtask : wait_on

  task automatic send(input logic st, input logic sp, input logic rc, input logic [7:0] b);
    wait_on(0, 4000);
    cmd_start = st;
    cmd_stop = sp;
    cmd_recover = rc;
    cmd_byte = b;
    cmd_valid = 1'h1;
    @(negedge clock);
    cmd_valid = 1'h0;
    if (!rc) wait_on(1, 2000);
    wait_on(0, 2000);
  endtask : send

  initial begin
    clock = 1'h0;
    rst = 1'h1;
    cmd_valid = 1'h0;
    cmd_start = 1'h0;
    cmd_stop = 1'h0;
    cmd_recover = 1'h0;
    cmd_byte = 8'h00;
    out_ready = 1'h0;
    straps = 3'h5;
    err_total = 0;
    n_tests = 0;
    repeat (16) @(negedge clock);
    rst = 1'h0;
    check(standby, 1'h1);
    check(link_if.sda, 1'h1);
    foreach (rows[r]) begin
      straps = rows[r].straps;
      send(1'h1, 1'h1, 1'h0, rows[r].addr);
      check(result_nack, rows[r].nack);
      check(result_nack2, rows[r].nack2);
      check(standby, 1'h1);
    end
    straps = 3'h5;
    send(1'h1, 1'h0, 1'h0, 8'haa);
    check(standby, 1'h0);
    for (i = 0; i < 17; i++) begin
      send(1'h0, i == 16, 1'h0, 8'h10 + 8'(i));
      check(result_nack, i == 16);
      check(result_byte, 8'h10 + 8'(i));
    end
    check(write_busy, 1'h1);
    send(1'h1, 1'h1, 1'h0, 8'haa);
    check(result_nack, 1'h1);
    check(write_busy, 1'h1);
    check(standby, 1'h0);
    wait_on(3, WR_P);
    check(standby, 1'h1);
    for (i = 0; i < 16; i++) begin
      wait_on(2, 10);
      check(out_data, 8'h10 + 8'(i));
      out_ready = 1'h1;
      @(negedge clock);
      out_ready = 1'h0;
    end
    check(out_valid, 1'h0);
    send(1'h1, 1'h0, 1'h0, 8'haa);
    send(1'h1, 1'h0, 1'h0, 8'hae);
    check(result_nack, 1'h1);
    send(1'h1, 1'h0, 1'h0, 8'hab);
    check(result_nack, 1'h0);
    send(1'h0, 1'h0, 1'h0, 8'hff);
    check(result_nack, 1'h1);
    check(result_byte, 8'hff);
    // Recovery is tried from an unfinished read, the case it exists for.
    send(1'h0, 1'h0, 1'h1, 8'h00);
    check(standby, 1'h1);
    check(write_busy, 1'h0);
    for (i = 0; i < 4; i++) begin
      send(i == 0, i == 3, 1'h0, (i == 0) ? 8'haa : 8'(i));
      check(result_nack, 1'h0);
    end
    repeat (20) @(negedge clock);
    rst = 1'h1;
    repeat (16) @(negedge clock);
    rst = 1'h0;
    check(write_busy, 1'h0);
    check(out_valid, 1'h0);
    check(standby, 1'h1);
    finish_test();
  end
endmodule : tb_top
